// [verilog/sto_mon_regs.vh]
// Constants for the safe torque off monitor
`ifndef STO_MON_REGS_VH
`define STO_MON_REGS_VH
`define STO_CLK_FREQ_HZ     25000000
`define STO_FILT_MIN_US     1000
`define STO_FILT_CYCLES     (`STO_FILT_MIN_US * (`STO_CLK_FREQ_HZ / 1000000))
`define STO_FILT_W          16
`define STO_DLY_W           24
`define STO_SPD_W           16
`define STO_ST_RUN          2'h0
`define STO_ST_TOFF         2'h1
`define STO_ST_SOFF         2'h2
`endif

// [verilog/sto_in_filter.v]
// Synchroniser and low-pulse filter for one safety input
`timescale 1ns/100ps
`default_nettype none
`include "sto_mon_regs.vh"
module sto_in_filter #(
  parameter FW = `STO_FILT_W
) (
  input  wire          clk_in,
  input  wire          resetn_in,
  input  wire          ce_in,
  input  wire          raw_in,
  input  wire [FW-1:0] thresh_in,
  output wire          off_out
);
  reg          off_ff;
  reg          sync1_ff;
  reg          sync2_ff;
  reg [FW-1:0] cnt_ff;
  reg [FW-1:0] nxt_cnt;
  reg          nxt_off;

  assign off_out = off_ff;

  // Safe default: input counts as off until proven on
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else if (ce_in) begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
    end
  end

  always @* begin
    nxt_cnt = cnt_ff;
    nxt_off = off_ff;
    if (sync2_ff) begin
      nxt_cnt = {FW{1'b0}};
      nxt_off = 1'b0;
    end else if (cnt_ff >= thresh_in) begin
      nxt_off = 1'b1;
    end else begin
      nxt_cnt = cnt_ff + {{(FW-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_ff <= {FW{1'b0}};
      off_ff <= 1'b1;
    end else if (ce_in) begin
      cnt_ff <= nxt_cnt;
      off_ff <= nxt_off;
    end
  end
endmodule // sto_in_filter
`default_nettype wire

// [verilog/sto_monitor.v]
// Safe torque off supervision: filtering, monitor output and stop sequencing
`timescale 1ns/100ps
`default_nettype none
`include "sto_mon_regs.vh"
module sto_monitor #(
  parameter FW = `STO_FILT_W,
  parameter DW = `STO_DLY_W,
  parameter SW = `STO_SPD_W
) (
  input  wire          core_clk_in,
  input  wire          resetn_in,
  input  wire          ce_in,
  input  wire          safety_input_one_in,
  input  wire          safety_input_two_in,
  input  wire [FW-1:0] filter_thresh_in,
  input  wire          servo_on_in,
  input  wire          drive_ok_in,
  input  wire          motor_running_in,
  input  wire [SW-1:0] motor_speed_in,
  input  wire [DW-1:0] brake_action_delay_in,
  input  wire [SW-1:0] brake_release_speed_in,
  input  wire          alarm_stop_sequence_in,
  input  wire          servooff_stop_sequence_in,
  output reg           external_monitor_out,
  output reg           torque_off_state_out,
  output reg           servo_ready_out,
  output reg           servo_active_out,
  output reg           upper_arm_en_out,
  output reg           lower_arm_en_out,
  output reg           brake_release_out,
  output reg           dyn_brake_out,
  output reg           alarm_out
);
  // -------------------------------------------------------------
  // Input filtering
  // -------------------------------------------------------------
  wire [1:0] raw_w;
  wire [1:0] off_w;
  assign raw_w = {safety_input_two_in, safety_input_one_in};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_in
      sto_in_filter #(
        .FW(FW)
      ) u_filt (
        .clk_in    (core_clk_in),
        .resetn_in (resetn_in),
        .ce_in     (ce_in),
        .raw_in    (raw_w[gi]),
        .thresh_in (filter_thresh_in),
        .off_out   (off_w[gi])
      );
    end
  endgenerate

  // -------------------------------------------------------------
  // State sequencing
  // -------------------------------------------------------------
  reg [1:0]    state_ff;
  reg [1:0]    nxt_state;
  reg [DW-1:0] brk_cnt_ff;
  reg [DW-1:0] nxt_brk_cnt;
  reg          nxt_brake;
  wire         any_off;
  wire         both_off;
  assign any_off  = off_w[0] | off_w[1];
  assign both_off = off_w[0] & off_w[1];

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      `STO_ST_RUN: begin
        if (any_off) begin
          nxt_state = `STO_ST_TOFF;
        end else if (!servo_on_in) begin
          nxt_state = `STO_ST_SOFF;
        end
      end
      `STO_ST_TOFF: begin
        // Return lands in servo-off even if servo-on is already high
        if (!any_off) begin
          nxt_state = `STO_ST_SOFF;
        end
      end
      `STO_ST_SOFF: begin
        if (any_off) begin
          nxt_state = `STO_ST_TOFF;
        end else if (servo_on_in && drive_ok_in) begin
          nxt_state = `STO_ST_RUN;
        end
      end
      default: begin
        nxt_state = `STO_ST_TOFF;
      end
    endcase
  end

  // -------------------------------------------------------------
  // Brake hold timer
  // -------------------------------------------------------------
  // Drop brake release on delay, low speed or stopped motor, whichever comes first
  always @* begin
    nxt_brk_cnt = brk_cnt_ff;
    nxt_brake   = brake_release_out;
    if (nxt_state == `STO_ST_RUN) begin
      nxt_brk_cnt = {DW{1'b0}};
      nxt_brake   = 1'b1;
    end else if (brake_release_out) begin
      if (!motor_running_in || (brk_cnt_ff >= brake_action_delay_in) ||
          (motor_speed_in < brake_release_speed_in)) begin
        nxt_brake = 1'b0;
      end else begin
        nxt_brk_cnt = brk_cnt_ff + {{(DW-1){1'b0}}, 1'b1};
      end
    end
  end

  // -------------------------------------------------------------
  // State and brake timer registers
  // -------------------------------------------------------------
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_ff          <= `STO_ST_TOFF;
      brk_cnt_ff        <= {DW{1'b0}};
      brake_release_out <= 1'b0;
    end else if (ce_in) begin
      state_ff          <= nxt_state;
      brk_cnt_ff        <= nxt_brk_cnt;
      brake_release_out <= nxt_brake;
    end
  end

  // -------------------------------------------------------------
  // Monitor output
  // -------------------------------------------------------------
  // Built from the filtered inputs, so self-test pulses never toggle it
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      external_monitor_out <= 1'b0;
    end else if (ce_in) begin
      external_monitor_out <= both_off;
    end
  end

  // -------------------------------------------------------------
  // Status outputs
  // -------------------------------------------------------------
  // Ready drops with any filtered off input, whatever the state
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      torque_off_state_out <= 1'b1;
      servo_ready_out      <= 1'b0;
      servo_active_out     <= 1'b0;
    end else if (ce_in) begin
      torque_off_state_out <= (nxt_state == `STO_ST_TOFF);
      servo_ready_out      <= !any_off && drive_ok_in;
      servo_active_out     <= (nxt_state == `STO_ST_RUN);
    end
  end

  // -------------------------------------------------------------
  // Power stage enables
  // -------------------------------------------------------------
  // Each channel cuts its own arm directly, one cycle after its filter reports off,
  // so a fault in the sequencer alone cannot keep both arms driven
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      upper_arm_en_out <= 1'b0;
      lower_arm_en_out <= 1'b0;
    end else if (ce_in) begin
      upper_arm_en_out <= !off_w[0] && (nxt_state == `STO_ST_RUN);
      lower_arm_en_out <= !off_w[1] && (nxt_state == `STO_ST_RUN);
    end
  end

  // -------------------------------------------------------------
  // Dynamic brake
  // -------------------------------------------------------------
  // Applied through reset, since no stop sequence has been chosen yet
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dyn_brake_out <= 1'b1;
    end else if (ce_in) begin
      if (nxt_state == `STO_ST_TOFF) begin
        dyn_brake_out <= alarm_stop_sequence_in;
      end else if (nxt_state == `STO_ST_SOFF) begin
        dyn_brake_out <= servooff_stop_sequence_in;
      end else begin
        dyn_brake_out <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------
  // Alarm
  // -------------------------------------------------------------
  // Torque-off is a normal state, not a fault, so it never alarms
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      alarm_out <= 1'b0;
    end else if (ce_in) begin
      alarm_out <= 1'b0;
    end
  end
endmodule // sto_monitor
`default_nettype wire

// [tb/sto_chk_monitor.sv]
// Assertion checker bound to the safe torque off monitor
`timescale 1ns/100ps
`default_nettype none
module sto_chk (
  input wire logic core_clk_in, resetn_in, safety_input_one_in, safety_input_two_in,
  input wire logic motor_running_in, external_monitor_out, torque_off_state_out,
  input wire logic servo_ready_out, servo_active_out, upper_arm_en_out,
  input wire logic [15:0] motor_speed_in, brake_release_speed_in,
  input wire logic lower_arm_en_out, brake_release_out, alarm_out
);
  wire a = safety_input_one_in;
  wire b = safety_input_two_in;
  wire t = torque_off_state_out;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  // Windows fit filter thresholds up to 6; larger thresholds need wider ones
  AST_NO_ALARM: assert property (!alarm_out) else $error("alarm raised");
  AST_MON_ON: assert property ((!a && !b)[*8] |-> ##[0:3] external_monitor_out)
    else $error("monitor inactive");
  AST_MON_OFF: assert property (a[*8] |-> ##[0:3] !external_monitor_out)
    else $error("monitor active");
  AST_TOFF: assert property ((!a)[*8] |-> ##[0:3] t && !upper_arm_en_out)
    else $error("no torque off");
  AST_LOWER: assert property ((!b)[*8] |-> ##[0:3] t && !lower_arm_en_out)
    else $error("lower arm on");
  AST_RET: assert property ((a && b)[*8] |-> ##[0:3] !t)
    else $error("stuck in torque off");
  AST_RDY: assert property (t |-> !servo_ready_out && !servo_active_out)
    else $error("ready in torque off");
  AST_BRAKE: assert property (t && !motor_running_in |-> ##[0:2] !brake_release_out)
    else $error("brake held open");
  // Window fits a brake action delay of 16 cycles
  AST_BRK_DLY: assert property ($rose(t) |-> ##[0:16] !brake_release_out)
    else $error("brake delay exceeded");
  AST_BRK_SPD: assert property (servo_active_out && motor_speed_in < brake_release_speed_in
    ##1 !servo_active_out |-> !brake_release_out)
    else $error("brake held below release speed");
endmodule // sto_chk
bind sto_monitor sto_chk u_chk (.*);
`default_nettype wire

// [tb/sto_safety_ctl.sv]
// Safety controller model with short self-test low pulses
`timescale 1ns/100ps
`default_nettype none
module sto_safety_ctl (
  input  wire logic clk_in,
  input  wire logic off_one_in,
  input  wire logic off_two_in,
  input  wire logic diag_in,
  output wire logic sf_one_out,
  output wire logic sf_two_out
);
  logic [1:0] pulse_ff = 2'h0;
  // Three-sample pulse, too short to be taken as a request
  always @(posedge clk_in) begin
    pulse_ff <= diag_in ? 2'h2 : pulse_ff - {1'b0, |pulse_ff};
  end
  wire quiet = !diag_in && pulse_ff == 2'h0;
  assign sf_one_out = !off_one_in && quiet;
  assign sf_two_out = !off_two_in && quiet;
endmodule // sto_safety_ctl
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking testbench of the safe torque off monitor
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clk, rstn, off1, off2, diag, son, run, aseq, sseq, chk;
  logic [15:0] spd;
  logic [8:0]  q [$];
  logic [8:0]  ex;
  integer      n_mismatch, checks_done, seed, i;
  wire         s1, s2, mon, toff, act, dyn, alm, rdy, up, lo, brk;
  wire [8:0]   got = {mon, toff, act, dyn, alm, rdy, up, lo, brk};
  sto_safety_ctl u_ctl (.clk_in(clk), .off_one_in(off1), .off_two_in(off2), .diag_in(diag),
    .sf_one_out(s1), .sf_two_out(s2));
  // Small filter threshold keeps the run short
  sto_monitor DUT (.core_clk_in(clk), .resetn_in(rstn), .ce_in(1'b1), .safety_input_one_in(s1),
    .safety_input_two_in(s2), .filter_thresh_in(16'h0004), .servo_on_in(son),
    .drive_ok_in(1'b1), .motor_running_in(run), .motor_speed_in(spd),
    .brake_action_delay_in(24'h000010), .brake_release_speed_in(16'h0100),
    .alarm_stop_sequence_in(aseq), .servooff_stop_sequence_in(sseq),
    .external_monitor_out(mon), .torque_off_state_out(toff), .servo_ready_out(rdy),
    .servo_active_out(act), .upper_arm_en_out(up), .lower_arm_en_out(lo),
    .brake_release_out(brk), .dyn_brake_out(dyn), .alarm_out(alm));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task step(input logic o1, o2, d, sn);
    begin
      off1 <= o1;
      off2 <= o2;
      son <= sn;
      diag <= d;
      // Motor keeps turning through torque-off; the brake timer runs out unless an odd combo's low speed drops the brake first
      run <= sn;
      spd <= 16'($random(seed)) & (i[0] ? 16'h00ff : 16'hffff);
      @(posedge clk) diag <= 1'b0;
      repeat (26) @(posedge clk);
      q.push_back({o1 & o2, o1 | o2, sn & !(o1 | o2), (o1 | o2) ? aseq : sseq & !sn, 1'b0,
        !(o1 | o2), {3{sn & !(o1 | o2)}}});
      chk <= 1'b1;
      @(posedge clk) chk <= 1'b0;
    end
  endtask
  always @(posedge clk) begin
    if (chk === 1'b1) begin
      ex = q.pop_front();
      checks_done = checks_done + 1;
      if (got !== ex) begin
        $display("wrong value at %0t: got %b want %b", $time, got, ex);
        n_mismatch = n_mismatch + 1;
      end
    end
  end
  task final_report;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    seed = 25;
    n_mismatch = 0;
    checks_done = 0;
    {rstn, off1, off2, diag, son, run, aseq, sseq, chk} = 9'h000;
    spd = 16'h0000;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      aseq <= 1'($random(seed));
      sseq <= 1'($random(seed));
      step(1'b0, 1'b0, 1'b0, 1'b0);
      step(1'b0, 1'b0, 1'b0, 1'b1);
      step(1'b0, 1'b0, 1'b1, 1'b1);
      step(i[1], i[0], 1'b0, 1'b1);
      $display("combo %0d done", i);
    end
    final_report;
  end
endmodule // tb_top
`default_nettype wire
